// *** flag_port_pkg.sv ***
// Constants and carriers for the semaphore port controller
package flag_port_pkg;
   localparam int FLAG_COUNT = 8;
   localparam int FLAG_IDX_W = 3;
   localparam int ADDR_W = 14;
   localparam int DATA_W = 9;
   localparam int CLK_PERIOD_NS = 4;
   localparam int SETUP_NS = 20;
   localparam int PULSE_NS = 20;
   localparam int GAP_NS = 12;
   localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PULSE_CYC = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int GAP_CYC = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 4;

   typedef enum logic [1:0] {
      OP_CLAIM,
      OP_RELEASE,
      OP_READ,
      OP_INIT
   } flag_op_e;

   typedef struct packed {
      flag_op_e op;
      logic [FLAG_IDX_W-1:0] idx;
   } flag_req_s;

   typedef struct packed {
      logic chip_en_n;
      logic flag_space_select_n;
      logic out_en_n;
      logic rd_wr_n;
      logic [ADDR_W-1:0] addr;
   } port_ctl_s;

   function automatic logic [CNT_W-1:0] cyc(input int n);
      cyc = CNT_W'(n);
   endfunction
endpackage

// *** flag_sync.sv ***
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module flag_sync #(
   parameter int W = 9
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s1_d;
   logic [W-1:0] q_d;

   always_comb begin
      s1_d = d;
      q_d = s1_q;
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         s1_q <= '0;
         q <= '0;
      end else begin
         s1_q <= s1_d;
         q <= q_d;
      end
   end
endmodule
`default_nettype wire

// *** flag_port_ctrl.sv ***
// Host-side controller for one port of the semaphore flag space
`timescale 1ns/1ps
`default_nettype none
// Function
// RL1 - Device holds eight flags apart from the RAM, reachable from both ports
// RL2 - Flags active low; write zero to claim, one to release
// RL3 - Flag space chosen by flag select low; address, output enable, read/write as SRAM
// RL4 - Low three address bits pick the flag; upper bits ignored
// RL5 - Only data bit zero counts on a flag write
// RL6 - Zero written to free flag reads zero here, one on far side
// RL7 - Only owner may change a flag; other side waits
// RL8 - Owner writing one frees flag unless other side is pending
// RL9 - Flag read returns value copied on all data bits
// RL10 - Read value latched when select and output enable go active
// RL11 - Drop select or output enable between polling reads
// RL12 - Claim by write zero then read back; never read first
// RL13 - Failed request keeps request latch low while flag reads one
// RL14 - Two request latches per flag; first zero wins until released
// RL15 - Pending far request takes ownership when owner releases
// RL16 - After failed claim keep reading or write one to withdraw
// RL17 - Simultaneous claims give exactly one side the token
// RL18 - At power-up write one to every flag from both ports
// RL19 - Hold RAM chip enable high while flag select is low
// RL20 - Flags gate no resource; meaning left to software
// RL21 - Flag accesses leave RAM unchanged and vice versa
module flag_port_ctrl
   import flag_port_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic req_valid,
   input wire flag_req_s req,
   output logic req_ready,
   output logic done,
   output logic owned,
   output logic flag_val,
   output port_ctl_s pins,
   output logic [DATA_W-1:0] data_out,
   output logic data_oe,
   input wire logic [DATA_W-1:0] data_in
);
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_SETUP,
      ST_WRITE,
      ST_GAP,
      ST_READ,
      ST_DONE
   } st_e;

   st_e st_q, st_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   flag_req_s cur_q, cur_d;
   logic [FLAG_IDX_W-1:0] init_q, init_d;
   logic done_d, owned_d, flag_val_d, ready_d, oe_d;
   port_ctl_s pins_d;
   logic [DATA_W-1:0] dout_d;
   logic [DATA_W-1:0] din_s;

   flag_sync #(.W(DATA_W)) u_sync (
      .ref_clk(ref_clk),
      .rst(rst),
      .d(data_in),
      .q(din_s)
   );

   function automatic port_ctl_s idle_pins();
      port_ctl_s p;
      p.chip_en_n = 1'b1;
      p.flag_space_select_n = 1'b1;
      p.out_en_n = 1'b1;
      p.rd_wr_n = 1'b1;
      p.addr = '0;
      return p;
   endfunction

   function automatic logic [ADDR_W-1:0] flag_addr(input logic [FLAG_IDX_W-1:0] i);
      return {{(ADDR_W-FLAG_IDX_W){1'b0}}, i}; // RL4
   endfunction

   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      cur_d = cur_q;
      init_d = init_q;
      done_d = 1'b0;
      owned_d = owned;
      flag_val_d = flag_val;
      ready_d = 1'b0;
      pins_d = pins;
      dout_d = data_out;
      oe_d = 1'b0;
      pins_d.chip_en_n = 1'b1; // RL19 RL21
      case (st_q)
         ST_IDLE: begin
            pins_d = idle_pins(); // RL11
            ready_d = 1'b1;
            if (req_valid && req_ready) begin
               cur_d = req;
               init_d = '0;
               ready_d = 1'b0;
               st_d = ST_SETUP;
               cnt_d = cyc(SETUP_CYC);
            end
         end
         ST_SETUP: begin
            pins_d.flag_space_select_n = 1'b0; // RL3
            pins_d.addr = flag_addr(cur_q.op == OP_INIT ? init_q : cur_q.idx);
            if (cur_q.op != OP_READ) begin
               dout_d = {{(DATA_W-1){1'b0}}, cur_q.op != OP_CLAIM}; // RL2 RL5
               oe_d = 1'b1;
            end
            if (cnt_q == '0) begin
               if (cur_q.op == OP_READ) begin
                  st_d = ST_READ;
                  cnt_d = cyc(PULSE_CYC + 2);
               end else begin
                  st_d = ST_WRITE;
                  cnt_d = cyc(PULSE_CYC);
               end
            end else begin
               cnt_d = cnt_q - 1'b1;
            end
         end
         ST_WRITE: begin
            oe_d = 1'b1;
            pins_d.rd_wr_n = (cnt_q == '0);
            if (cnt_q == '0) begin
               st_d = ST_GAP;
               cnt_d = cyc(GAP_CYC);
               pins_d = idle_pins(); // RL11
            end else begin
               cnt_d = cnt_q - 1'b1;
            end
         end
         ST_GAP: begin
            pins_d = idle_pins();
            if (cnt_q != '0) begin
               cnt_d = cnt_q - 1'b1;
            end else if (cur_q.op == OP_CLAIM) begin
               st_d = ST_SETUP; // RL12
               cur_d.op = OP_READ;
               cnt_d = cyc(SETUP_CYC);
            end else if (cur_q.op == OP_INIT && init_q != FLAG_IDX_W'(FLAG_COUNT - 1)) begin
               init_d = init_q + 1'b1; // RL18
               st_d = ST_SETUP;
               cnt_d = cyc(SETUP_CYC);
            end else begin
               if (cur_q.op == OP_RELEASE || cur_q.op == OP_INIT) begin
                  owned_d = 1'b0;
                  flag_val_d = 1'b1;
               end
               st_d = ST_DONE;
            end
         end
         ST_READ: begin
            pins_d.out_en_n = 1'b0; // RL10
            if (cnt_q == '0) begin
               flag_val_d = din_s[0]; // RL9
               owned_d = ~din_s[0]; // RL6 RL13 RL16
               pins_d = idle_pins(); // RL11
               st_d = ST_DONE;
            end else begin
               cnt_d = cnt_q - 1'b1;
            end
         end
         ST_DONE: begin
            done_d = 1'b1;
            pins_d = idle_pins();
            st_d = ST_IDLE;
         end
         default: begin
            st_d = ST_IDLE;
            pins_d = idle_pins();
         end
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st_q <= ST_IDLE;
         cnt_q <= '0;
         cur_q <= '0;
         init_q <= '0;
         done <= 1'b0;
         owned <= 1'b0;
         flag_val <= 1'b1;
         req_ready <= 1'b0;
         pins <= '{1'b1, 1'b1, 1'b1, 1'b1, '0};
         data_out <= '0;
         data_oe <= 1'b0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         cur_q <= cur_d;
         init_q <= init_d;
         done <= done_d;
         owned <= owned_d;
         flag_val <= flag_val_d;
         req_ready <= ready_d;
         pins <= pins_d;
         data_out <= dout_d;
         data_oe <= oe_d;
      end
   end

   sequence write_pulse_s;
      !pins.rd_wr_n && !pins.flag_space_select_n;
   endsequence

   chip_en_high_a: assert property (@(posedge ref_clk) disable iff (rst) // RL19
      !pins.flag_space_select_n |-> pins.chip_en_n)
      else $error("chip enable low during flag access");
   addr_high_zero_a: assert property (@(posedge ref_clk) disable iff (rst) // RL4
      !pins.flag_space_select_n |-> pins.addr[ADDR_W-1:FLAG_IDX_W] == '0)
      else $error("upper address bits not zero");
   write_data_drive_a: assert property (@(posedge ref_clk) disable iff (rst) // RL5
      write_pulse_s |-> data_oe && data_out[DATA_W-1:1] == '0)
      else $error("write without clean data");
   no_read_write_a: assert property (@(posedge ref_clk) disable iff (rst) // RL3
      !pins.out_en_n |-> pins.rd_wr_n && !data_oe)
      else $error("read overlaps write");
   poll_release_a: assert property (@(posedge ref_clk) disable iff (rst) // RL11
      $rose(done) |-> $past(pins.out_en_n) || $past(pins.flag_space_select_n))
      else $error("select not dropped after read");
   claim_readback_a: assert property (@(posedge ref_clk) disable iff (rst) // RL12
      (write_pulse_s and cur_q.op == OP_CLAIM) |-> ##[1:40] !pins.out_en_n)
      else $error("claim not read back");
   owned_update_a: assert property (@(posedge ref_clk) disable iff (rst) // RL6
      (st_q == ST_READ && cnt_q == '0) |=> owned == ~$past(din_s[0]))
      else $error("ownership not taken from read");
   release_free_a: assert property (@(posedge ref_clk) disable iff (rst) // RL2
      (done && cur_q.op == OP_RELEASE) |-> !owned && flag_val)
      else $error("release did not free");
   init_all_a: assert property (@(posedge ref_clk) disable iff (rst) // RL18
      (done && cur_q.op == OP_INIT) |-> init_q == FLAG_IDX_W'(FLAG_COUNT - 1))
      else $error("init stopped early");
endmodule
`default_nettype wire

// *** flag_dev_model.sv ***
// Behavioural two-port semaphore flag device
`timescale 1ns/1ps
`default_nettype none
module flag_dev_model
   import flag_port_pkg::*;
(
   input wire logic ref_clk,
   input wire port_ctl_s a,
   input wire logic [DATA_W-1:0] a_d,
   output logic [DATA_W-1:0] a_q,
   input wire port_ctl_s b,
   input wire logic [DATA_W-1:0] b_d,
   output logic [DATA_W-1:0] b_q
);
   // Latches power up as pending requests until written one
   logic [7:0] ra = 8'h00, rb = 8'h00, oa = 8'h00, ob = 8'h00;
   logic la = 1'b0, lb = 1'b0, ar_q = 1'b0, br_q = 1'b0, tog = 1'b0;
   wire logic ar = !a.flag_space_select_n && a.chip_en_n && !a.out_en_n && a.rd_wr_n;
   wire logic br = !b.flag_space_select_n && b.chip_en_n && !b.out_en_n && b.rd_wr_n;
   function automatic logic wr(input port_ctl_s p);
      return !p.flag_space_select_n && p.chip_en_n && !p.rd_wr_n;
   endfunction
   always @(posedge ref_clk) begin
      logic [7:0] na, nb, noa, nob;
      na = ra;
      nb = rb;
      noa = oa;
      nob = ob;
      if (wr(a)) na[a.addr[2:0]] = a_d[0];
      if (wr(b)) nb[b.addr[2:0]] = b_d[0];
      for (int i = 0; i < 8; i++) begin
         if (noa[i] && na[i]) noa[i] = 1'b0;
         if (nob[i] && nb[i]) nob[i] = 1'b0;
         if (!noa[i] && !nob[i] && !na[i]) noa[i] = 1'b1;
         else if (!noa[i] && !nob[i] && !nb[i]) nob[i] = 1'b1;
      end
      if (ar && !ar_q) la <= ~noa[a.addr[2:0]];
      if (br && !br_q) lb <= ~nob[b.addr[2:0]];
      tog <= ~tog;
      ra <= na;
      rb <= nb;
      oa <= noa;
      ob <= nob;
      ar_q <= ar;
      br_q <= br;
   end
   // Flags gate nothing else; a released bus toggles
   assign a_q = ar_q ? {DATA_W{la}} : {DATA_W{tog}};
   assign b_q = br_q ? {DATA_W{lb}} : {DATA_W{tog}};
endmodule
`default_nettype wire

// *** flag_port_ctrl_test.sv ***
// Self-checking bench for the semaphore port controller
`timescale 1ns/1ps
`default_nettype none
module flag_port_ctrl_test
   import flag_port_pkg::*;
;
   logic ref_clk = 1'b0, rst = 1'b1, req_valid = 1'b0, req_ready, done, owned, flag_val, data_oe;
   flag_req_s req = '{OP_READ, 3'h0};
   port_ctl_s pins, bp = '{1'b1, 1'b1, 1'b1, 1'b1, 14'h0000};
   logic [DATA_W-1:0] data_out, data_in, a_q, b_q, b_d = 9'h000;
   int err_count = 0, n_compared = 0;
   always #2 ref_clk = ~ref_clk;
   assign data_in = data_oe ? data_out : a_q;
   flag_port_ctrl dut_u (.ref_clk(ref_clk), .rst(rst), .req_valid(req_valid), .req(req), .req_ready(req_ready),
      .done(done), .owned(owned), .flag_val(flag_val), .pins(pins), .data_out(data_out), .data_oe(data_oe),
      .data_in(data_in));
   flag_dev_model dev_u (.ref_clk(ref_clk), .a(pins), .a_d(data_out), .a_q(a_q), .b(bp), .b_d(b_d), .b_q(b_q));
   task automatic end_of_test();
      $display("Compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic got, input logic exp, input string what);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t %s", $time, what);
      end
   endtask
   task automatic chkv(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t %s", $time, what);
      end
   endtask
   task automatic op(input flag_op_e o, input logic [2:0] idx);
      int n;
      n = 0;
      while (req_ready !== 1'b1 && n < 400) begin
         @(negedge ref_clk);
         n++;
      end
      req = '{o, idx};
      req_valid = 1'b1;
      @(negedge ref_clk);
      req_valid = 1'b0;
      while (done !== 1'b1 && n < 400) begin
         @(negedge ref_clk);
         n++;
      end
      if (n >= 400) begin
         err_count++;
         $display("[FAIL] %0t no completion", $time);
         end_of_test();
      end
   endtask
   // Far port access; upper address and data bits carry junk
   task automatic bacc(input logic wr, input logic [2:0] idx, input logic v);
      bp = '{1'b1, 1'b0, wr, ~wr, {11'h5a5, idx}};
      b_d = {8'haa, v};
      repeat (4) @(negedge ref_clk);
      if (!wr) chkv(b_q, {DATA_W{v}}, "far read value");
      bp = '{1'b1, 1'b1, 1'b1, 1'b1, 14'h0000};
      b_d = 9'h1ff;
      repeat (2) @(negedge ref_clk);
   endtask
   always @(negedge ref_clk) begin
      if (!rst && !pins.flag_space_select_n) chk(pins.chip_en_n, 1'b1, "chip enable low in flag space");
      if (!rst && data_oe) chkv(data_out & 9'h1fe, 9'h000, "upper write bits set");
   end
   task automatic t_init();
      op(OP_INIT, 3'h0);
      for (int i = 0; i < 8; i++) bacc(1'b1, 3'(i), 1'b1);
      chk(flag_val, 1'b1, "flag not free after init");
      chk(owned, 1'b0, "owned after init");
   endtask
   task automatic t_all();
      for (int i = 0; i < 8; i++) begin
         op(OP_CLAIM, 3'(i));
         chk(owned, 1'b1, "claim of free flag lost");
         chk(flag_val, 1'b0, "claimed flag not low");
         bacc(1'b0, 3'(i), 1'b1);
         op(OP_RELEASE, 3'(i));
         chk(owned, 1'b0, "owned after release");
      end
   endtask
   task automatic t_pass();
      op(OP_CLAIM, 3'h5);
      bacc(1'b1, 3'h5, 1'b0);
      bacc(1'b0, 3'h5, 1'b1);
      op(OP_READ, 3'h5);
      chk(owned, 1'b1, "owner lost flag to far write");
      op(OP_RELEASE, 3'h5);
      bacc(1'b0, 3'h5, 1'b0);
      op(OP_READ, 3'h5);
      chk(flag_val, 1'b1, "flag not handed over");
      bacc(1'b1, 3'h5, 1'b1);
      op(OP_READ, 3'h5);
      chk(flag_val, 1'b1, "flag not free");
      bacc(1'b0, 3'h5, 1'b1);
   endtask
   task automatic t_withdraw();
      bacc(1'b1, 3'h2, 1'b0);
      op(OP_CLAIM, 3'h2);
      chk(owned, 1'b0, "claim of taken flag won");
      chk(flag_val, 1'b1, "taken flag read low");
      op(OP_RELEASE, 3'h2);
      bacc(1'b1, 3'h2, 1'b1);
      op(OP_READ, 3'h2);
      chk(flag_val, 1'b1, "stale request took flag");
   endtask
   initial begin
      repeat (16) @(negedge ref_clk);
      rst = 1'b0;
      t_init();
      t_all();
      t_pass();
      t_withdraw();
      end_of_test();
   end
endmodule
`default_nettype wire
